// >>> core/frfr_pkg.sv
// Shared constants and types for the FIFO read-side, reset, flag and retransmit control.
// Assumes one 40 MHz system clock; every FIFO pin is sampled through a two-stage synchroniser.
package frfr_pkg;

   // ==========================================================
   // Geometry
   localparam int DATA_W = 36;
   localparam int ADDR_W = 10;
   localparam int PTR_W = 11;
   localparam int OFS_W = 10;
   localparam int PIN_W = 56;
   localparam logic [10:0] DEPTH_CNT = 11'h400;

   // ==========================================================
   // Wishbone register map
   localparam logic [7:0] ADR_OFFSETS = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam int OFS_EMPTY_LSB = 0;
   localparam int OFS_FULL_LSB = 16;
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_EMPTY_N_BIT = 16;
   localparam int ST_NEAR_EMPTY_BIT = 17;
   localparam int ST_NEAR_FULL_BIT = 18;
   localparam int ST_FALL_THROUGH_MODE_BIT = 19;
   localparam int ST_SYNC_FLAG_BIT = 20;
   localparam int ST_ZERO_RT_BIT = 21;
   localparam int ST_ASYNC_RD_BIT = 22;
   localparam int ST_WIDTH_LSB = 23;
   localparam int ST_LITTLE_END_BIT = 25;
   localparam int ST_PARITY_BIT = 26;
   localparam int ST_PARALLEL_BIT = 27;

   // ==========================================================
   // Reset values
   localparam logic RST_NEAR_EMPTY_N = 1'b0;
   localparam logic RST_NEAR_FULL_N = 1'b1;
   localparam logic RST_EMPTY_N = 1'b0;

   // Default offsets chosen by {offset select pin, default select[1:0]}
   localparam logic [7:0][9:0] DEF_OFS = {
      10'h3FF, 10'h1FF, 10'h0FF, 10'h07F, 10'h03F, 10'h01F, 10'h00F, 10'h007
   };

   // ==========================================================
   // Read-port width
   typedef enum logic [1:0] {
      FRFR_WID_36 = 2'h0,
      FRFR_WID_18 = 2'h1,
      FRFR_WID_9 = 2'h2
   } frfr_width_t;

endpackage

// >>> core/frfr_sync.sv
// Multi-bit two-flop synchroniser for asynchronous pins.
// Assumes each bit is an independent level; no word coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module frfr_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } frfr_sync_state_t;

   frfr_sync_state_t s;
   frfr_sync_state_t next_s;

   always_comb begin
      next_s.meta = async_i;
      next_s.stable = s.meta;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_o = s.stable;
endmodule
`default_nettype wire

// >>> core/frfr_flags.sv
// Programmable near-empty / near-full flag generation.
// Assumes count and offsets come from the same clock; ticks mark synced pin edges.
`timescale 1ns/1ps
`default_nettype none
module frfr_flags (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic sync_mode_i,
   input wire logic rd_tick_i,
   input wire logic wr_tick_i,
   input wire logic [10:0] count_i,
   input wire logic [9:0] empty_ofs_i,
   input wire logic [9:0] full_ofs_i,
   output logic near_empty_n_o,
   output logic near_full_n_o
);
   typedef struct packed {
      logic near_empty_n;
      logic near_full_n;
   } frfr_flags_state_t;

   frfr_flags_state_t s;
   frfr_flags_state_t next_s;
   logic [10:0] free;
   logic ne_n;
   logic nf_n;

   always_comb begin
      free = frfr_pkg::DEPTH_CNT - count_i;
      ne_n = (count_i >= {1'b0, empty_ofs_i});
      nf_n = (free > {1'b0, full_ofs_i});
      next_s = s;
      if (clear_i) begin
         next_s.near_empty_n = frfr_pkg::RST_NEAR_EMPTY_N;
         next_s.near_full_n = frfr_pkg::RST_NEAR_FULL_N;
      end else if (sync_mode_i) begin
         // Each flag only moves on its own port's clock edge
         if (rd_tick_i) begin
            next_s.near_empty_n = ne_n;
         end
         if (wr_tick_i) begin
            next_s.near_full_n = nf_n;
         end
      end else begin
         next_s.near_empty_n = ne_n;
         next_s.near_full_n = nf_n;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s.near_empty_n <= frfr_pkg::RST_NEAR_EMPTY_N;
         s.near_full_n <= frfr_pkg::RST_NEAR_FULL_N;
      end else begin
         s <= next_s;
      end
   end

   assign near_empty_n_o = s.near_empty_n;
   assign near_full_n_o = s.near_full_n;
endmodule
`default_nettype wire

// >>> core/frfr_top.sv
// FIFO core: storage, resets, mode latching, read port, retransmit and flags.
// Assumes all FIFO pins are asynchronous to clk_i and far slower than it;
// a Wishbone classic slave gives software the offsets and a status view.
//
// Contract
// - Master reset zeroes read and write pointers and the output register.
// - Configuration pins are captured while master reset is held.
// - Partial reset zeroes both pointers and the output register.
// - Partial reset keeps timing mode, programming method and flag offsets.
// - Near-empty flag low when stored words below empty offset, else high.
// - Near-full flag low when free locations at most full offset, else high.
// - Flag-timing pin low selects asynchronous flags, high synchronous.
// - Synchronous mode: enabled read-clock edge reads one word or offset.
// - Offset-access select low puts offset registers on the outputs instead.
// - Asynchronous mode: each read strobe edge reads a word; enable tied low.
// - Read enable gates read clock for both memory and offset reads.
// - Retransmit-latency pin low selects zero latency, high normal latency.
// - Retransmit on read edge zeroes read pointer and shows empty or not-ready.
// - Retransmit leaves write pointer, modes and flag offsets untouched.
// - Read width comes from read, write width and bus-match selects.
// - Reads are 36, 18 or 9 bits; unused upper bits read as zero.
// - Output enable switches data outputs between driven and released.
// - Fall-through pin picks mode at master reset, serial input afterwards; the core ignores the pin after master reset.
// - Shared flag shows empty in standard mode, data valid in fall-through.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module frfr_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic full_init_reset_n_i,
   input wire logic data_only_reset_n_i,
   input wire logic write_clk_i,
   input wire logic write_enable_n_i,
   input wire logic [35:0] write_data_i,
   input wire logic read_clk_i,
   input wire logic read_enable_n_i,
   input wire logic offset_access_select_n_i,
   input wire logic retransmit_request_n_i,
   input wire logic output_enable_n_i,
   input wire logic fall_through_serial_in_i,
   input wire logic read_width_select_i,
   input wire logic write_width_select_i,
   input wire logic bus_match_select_i,
   input wire logic byte_order_select_i,
   input wire logic parity_select_i,
   input wire logic flag_timing_select_i,
   input wire logic retransmit_latency_select_i,
   input wire logic async_read_select_n_i,
   input wire logic [1:0] offset_default_select_i,
   output logic [35:0] read_data_out_o,
   output logic read_data_oe_o,
   output logic empty_flag_n_o,
   output logic near_empty_flag_n_o,
   output logic near_full_flag_n_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [10:0] wptr;
      logic [10:0] rptr;
      logic [1:0] pidx;
      logic [35:0] q;
      logic oe;
      logic out_valid;
      logic rt_block;
      logic ofs_rd_full;
      logic ofs_wr_full;
      logic [9:0] empty_ofs;
      logic [9:0] full_ofs;
      logic fall_through_mode;
      logic sync_flags;
      logic zero_rt;
      logic async_rd;
      logic parallel_ofs;
      logic little_end;
      logic parity;
      frfr_pkg::frfr_width_t width;
      logic prev_wclk;
      logic prev_rclk;
      logic empty_n;
      logic ack;
      logic [31:0] rdat;
   } frfr_state_t;

   frfr_state_t s;
   frfr_state_t next_s;
   logic [35:0] mem [0:1023];

   // ==========================================================
   // Pin synchronisation
   logic [frfr_pkg::PIN_W-1:0] pins_sync;
   logic [35:0] wdata;
   logic wclk, wen_n, rclk, ren_n, ld_n, rt_n, oe_n, mrs_n, prs_n, fall_through_serial_in;
   logic ow, iw, bm, be, ip, flag_timing_select, rm, asyr_n;
   logic [1:0] fsel;

   frfr_sync #(
      .W(frfr_pkg::PIN_W)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({write_data_i, write_clk_i, write_enable_n_i, read_clk_i, read_enable_n_i,
                offset_access_select_n_i, retransmit_request_n_i, output_enable_n_i,
                full_init_reset_n_i, data_only_reset_n_i, fall_through_serial_in_i,
                read_width_select_i, write_width_select_i, bus_match_select_i,
                byte_order_select_i, parity_select_i, flag_timing_select_i,
                retransmit_latency_select_i, async_read_select_n_i, offset_default_select_i}),
      .sync_o(pins_sync)
   );

   assign {wdata, wclk, wen_n, rclk, ren_n, ld_n, rt_n, oe_n, mrs_n, prs_n, fall_through_serial_in,
           ow, iw, bm, be, ip, flag_timing_select, rm, asyr_n, fsel} = pins_sync;

   // ==========================================================
   // Narrow read slicing
   function automatic logic [35:0] slice(input logic [35:0] w, input frfr_pkg::frfr_width_t wid,
                                         input logic [1:0] idx, input logic little);
      logic [1:0] k;
      logic [35:0] r;
      k = little ? idx : ~idx;
      r = 36'h0_0000_0000;
      case (wid)
         frfr_pkg::FRFR_WID_18: r[17:0] = (little ? idx[0] : ~idx[0]) ? w[35:18] : w[17:0];
         frfr_pkg::FRFR_WID_9: r[8:0] = w[9*k +: 9];
         default: r = w;
      endcase
      return r;
   endfunction

   function automatic logic [1:0] last_idx(input frfr_pkg::frfr_width_t wid);
      case (wid)
         frfr_pkg::FRFR_WID_18: return 2'h1;
         frfr_pkg::FRFR_WID_9: return 2'h3;
         default: return 2'h0;
      endcase
   endfunction

   // ==========================================================
   // Next-state logic
   logic wedge, redge, wr_fire, ofs_wr, rd_fire, rt_fire, consume, load, clear;
   logic [10:0] cnt;
   logic [10:0] next_cnt;
   logic empty, full, bus_hit;
   logic [35:0] word;
   logic [31:0] merged;
   logic [31:0] status;

   assign word = mem[s.rptr[9:0]];
   assign cnt = s.wptr - s.rptr;

   always_comb begin
      next_s = s;
      next_s.prev_wclk = wclk;
      next_s.prev_rclk = rclk;
      wedge = wclk & ~s.prev_wclk;
      redge = rclk & ~s.prev_rclk;
      empty = (cnt == 11'h000);
      full = (cnt == frfr_pkg::DEPTH_CNT);
      wr_fire = wedge & ~wen_n & ld_n & ~full;
      ofs_wr = wedge & ~wen_n & ~ld_n & s.parallel_ofs;
      rd_fire = redge & (s.async_rd | ~ren_n);
      rt_fire = redge & ~rt_n;
      consume = rd_fire & s.out_valid;
      load = 1'b0;
      clear = ~mrs_n | ~prs_n;
      next_s.oe = ~oe_n;

      if (!mrs_n) begin
         next_s.wptr = 11'h000;
         next_s.rptr = 11'h000;
         next_s.q = 36'h0_0000_0000;
         next_s.pidx = 2'h0;
         next_s.out_valid = 1'b0;
         next_s.rt_block = 1'b0;
         next_s.ofs_rd_full = 1'b0;
         next_s.ofs_wr_full = 1'b0;
         // Pins are relied on to stay put afterwards, so capture is continuous while held
         next_s.async_rd = ~asyr_n;
         next_s.fall_through_mode = fall_through_serial_in & asyr_n;
         next_s.sync_flags = flag_timing_select;
         next_s.zero_rt = ~rm;
         next_s.parallel_ofs = ld_n;
         next_s.little_end = be;
         next_s.parity = ip;
         next_s.empty_ofs = frfr_pkg::DEF_OFS[{ld_n, fsel}];
         next_s.full_ofs = frfr_pkg::DEF_OFS[{ld_n, fsel}];
         if (!bm || !ow) begin
            next_s.width = frfr_pkg::FRFR_WID_36;
         end else if (!iw) begin
            next_s.width = frfr_pkg::FRFR_WID_18;
         end else begin
            next_s.width = frfr_pkg::FRFR_WID_9;
         end
      end else if (!prs_n) begin
         // Modes and offsets deliberately not touched here
         next_s.wptr = 11'h000;
         next_s.rptr = 11'h000;
         next_s.q = 36'h0_0000_0000;
         next_s.pidx = 2'h0;
         next_s.out_valid = 1'b0;
         next_s.rt_block = 1'b0;
         next_s.ofs_rd_full = 1'b0;
         next_s.ofs_wr_full = 1'b0;
      end else begin
         if (wr_fire) begin
            next_s.wptr = s.wptr + 11'h001;
         end
         if (ofs_wr) begin
            if (s.ofs_wr_full) begin
               next_s.full_ofs = wdata[9:0];
            end else begin
               next_s.empty_ofs = wdata[9:0];
            end
            next_s.ofs_wr_full = ~s.ofs_wr_full;
         end
         if (rt_fire) begin
            // Write side and modes are left alone so the reread starts at location zero
            next_s.rptr = 11'h000;
            next_s.pidx = 2'h0;
            next_s.out_valid = 1'b0;
            next_s.rt_block = 1'b1;
         end else if (rd_fire && !s.async_rd && !ld_n) begin
            next_s.q = {26'h000_0000, s.ofs_rd_full ? s.full_ofs : s.empty_ofs};
            next_s.ofs_rd_full = ~s.ofs_rd_full;
         end else if (s.rt_block && !s.zero_rt) begin
            // Normal latency: one read edge is swallowed after a retransmit
            if (rd_fire) begin
               next_s.rt_block = 1'b0;
            end
         end else begin
            if (s.fall_through_mode) begin
               load = (~s.out_valid | consume) & ~empty;
            end else begin
               load = rd_fire & ~empty;
            end
            if (load) begin
               next_s.q = slice(word, s.width, s.pidx, s.little_end);
               next_s.out_valid = 1'b1;
               next_s.rt_block = 1'b0;
               if (s.pidx == last_idx(s.width)) begin
                  next_s.pidx = 2'h0;
                  next_s.rptr = s.rptr + 11'h001;
               end else begin
                  next_s.pidx = s.pidx + 2'h1;
               end
            end else if (consume) begin
               next_s.out_valid = 1'b0;
            end
         end
      end

      next_cnt = next_s.wptr - next_s.rptr;
      if (next_s.fall_through_mode) begin
         next_s.empty_n = ~next_s.out_valid;
      end else begin
         next_s.empty_n = (next_cnt != 11'h000) & ~next_s.rt_block;
      end

      // Wishbone classic slave, one wait state, unmapped reads zero
      bus_hit = wb_cyc_i & wb_stb_i & ~s.ack;
      next_s.ack = bus_hit;
      status = 32'h0000_0000;
      status[frfr_pkg::ST_COUNT_LSB +: 11] = cnt;
      status[frfr_pkg::ST_EMPTY_N_BIT] = s.empty_n;
      status[frfr_pkg::ST_NEAR_EMPTY_BIT] = near_empty_flag_n_o;
      status[frfr_pkg::ST_NEAR_FULL_BIT] = near_full_flag_n_o;
      status[frfr_pkg::ST_FALL_THROUGH_MODE_BIT] = s.fall_through_mode;
      status[frfr_pkg::ST_SYNC_FLAG_BIT] = s.sync_flags;
      status[frfr_pkg::ST_ZERO_RT_BIT] = s.zero_rt;
      status[frfr_pkg::ST_ASYNC_RD_BIT] = s.async_rd;
      status[frfr_pkg::ST_WIDTH_LSB +: 2] = s.width;
      status[frfr_pkg::ST_LITTLE_END_BIT] = s.little_end;
      status[frfr_pkg::ST_PARITY_BIT] = s.parity;
      status[frfr_pkg::ST_PARALLEL_BIT] = s.parallel_ofs;
      merged = 32'h0000_0000;
      merged[frfr_pkg::OFS_EMPTY_LSB +: 10] = s.empty_ofs;
      merged[frfr_pkg::OFS_FULL_LSB +: 10] = s.full_ofs;
      if (bus_hit) begin
         next_s.rdat = 32'h0000_0000;
         if (wb_adr_i == frfr_pkg::ADR_OFFSETS) begin
            next_s.rdat = merged;
            if (wb_we_i && mrs_n) begin
               for (int b = 0; b < 4; b++) begin
                  if (wb_sel_i[b]) begin
                     merged[8*b +: 8] = wb_dat_i[8*b +: 8];
                  end
               end
               next_s.empty_ofs = merged[frfr_pkg::OFS_EMPTY_LSB +: 10];
               next_s.full_ofs = merged[frfr_pkg::OFS_FULL_LSB +: 10];
            end
         end else if (wb_adr_i == frfr_pkg::ADR_STATUS) begin
            next_s.rdat = status;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.empty_n <= frfr_pkg::RST_EMPTY_N;
         s.parallel_ofs <= 1'b1;
         s.zero_rt <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Storage kept outside the state record; plain write port only
   always_ff @(posedge clk_i) begin
      if (!rst_i && mrs_n && prs_n && wr_fire) begin
         mem[s.wptr[9:0]] <= wdata;
      end
   end

   // ==========================================================
   // Flags
   frfr_flags u_flags (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(clear),
      .sync_mode_i(s.sync_flags),
      .rd_tick_i(redge),
      .wr_tick_i(wedge),
      .count_i(cnt),
      .empty_ofs_i(s.empty_ofs),
      .full_ofs_i(s.full_ofs),
      .near_empty_n_o(near_empty_flag_n_o),
      .near_full_n_o(near_full_flag_n_o)
   );

   assign read_data_out_o = s.q;
   assign read_data_oe_o = s.oe;
   assign empty_flag_n_o = s.empty_n;
   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
endmodule
`default_nettype wire

// >>> test/frfr_checker.sv
// Checker: bus handshake, reset clearing and output-enable relations of frfr_top.
// Assumes it is bound to frfr_top and that every pin is slow against clk_i.
`timescale 1ns/1ps
`default_nettype none
module frfr_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic full_init_reset_n_i,
   input wire logic data_only_reset_n_i,
   input wire logic fall_through_serial_in_i,
   input wire logic async_read_select_n_i,
   input wire logic output_enable_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [35:0] read_data_out_o,
   input wire logic read_data_oe_o,
   input wire logic empty_flag_n_o,
   input wire logic near_empty_flag_n_o,
   input wire logic near_full_flag_n_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic unmapped = wb_adr_i != frfr_pkg::ADR_OFFSETS && wb_adr_i != frfr_pkg::ADR_STATUS;
   // ==========================================================
   // Register bus
   ack_answer_a: assert property (bus_req |=> wb_ack_o) else $error("bus request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(bus_req)) else $error("ack without request");
   unmapped_read_a: assert property (bus_req && !wb_we_i && unmapped |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   // ==========================================================
   // Resets and output enable; pins pass a synchroniser, so only a held level is judged
   mrs_clear_a: assert property (!full_init_reset_n_i [*6] |-> read_data_out_o == 36'h0 &&
      !near_empty_flag_n_o && near_full_flag_n_o) else $error("master reset did not clear");
   mrs_mode_a: assert property (!full_init_reset_n_i [*6] |->
      empty_flag_n_o == (fall_through_serial_in_i && async_read_select_n_i)) else $error("shared flag wrong");
   prs_clear_a: assert property (!data_only_reset_n_i [*6] |-> read_data_out_o == 36'h0)
      else $error("partial reset did not clear");
   oe_drive_a: assert property (!output_enable_n_i [*4] |-> read_data_oe_o)
      else $error("outputs not driven");
   oe_release_a: assert property (output_enable_n_i [*4] |-> !read_data_oe_o)
      else $error("outputs not released");
   cover property (wb_ack_o && !wb_we_i);
   cover property ($fell(empty_flag_n_o));
   cover property ($rose(near_empty_flag_n_o));
endmodule
`default_nettype wire

// >>> test/frfr_pin_partner.sv
// Far-side writer and reader logic on the FIFO pins.
// Assumes clk_i is the core clock; each pin level is held 4 clk, a cycle is 8 or more.
`timescale 1ns/1ps
`default_nettype none
module frfr_pin_partner (
   input wire logic clk_i,
   output logic write_clk_o,
   output logic write_enable_n_o,
   output logic [35:0] write_data_o,
   output logic read_clk_o,
   output logic read_enable_n_o,
   output logic retransmit_request_n_o,
   output logic offset_access_select_n_o
);
   initial begin
      write_clk_o = 1'b0;
      write_enable_n_o = 1'b1;
      write_data_o = 36'h5_5555_5555;
      read_clk_o = 1'b0;
      read_enable_n_o = 1'b1;
      retransmit_request_n_o = 1'b1;
      offset_access_select_n_o = 1'b1;
   end
   task automatic write_word(input logic [35:0] d);
      @(posedge clk_i);
      write_data_o <= d;
      write_enable_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      write_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      write_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      write_enable_n_o <= 1'b1;
      // Released data must not look valid
      write_data_o <= ~d;
   endtask
   task automatic read_edge(input logic en_n, input logic rt_n, input logic ld_n);
      @(posedge clk_i);
      read_enable_n_o <= en_n;
      retransmit_request_n_o <= rt_n;
      offset_access_select_n_o <= ld_n;
      repeat (4) @(posedge clk_i);
      read_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      read_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      read_enable_n_o <= 1'b1;
      retransmit_request_n_o <= 1'b1;
      offset_access_select_n_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> test/fifo_reset_flag_retransmit_ctl_bench.sv
// Self-checking bench for frfr_top: resets, flags, reads, retransmit, widths.
// Assumes frfr_pin_partner drives the write and read pins; the bench drives resets, OE and config pins and plays Wishbone master.
`timescale 1ns/1ps
`default_nettype none
module fifo_reset_flag_retransmit_ctl_bench;
   localparam logic [35:0] WBASE = 36'hC_3C3C_3C30;
   localparam logic [31:0] ST_IDLE = 32'h0024_0000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic mrs_n = 1'b1;
   logic prs_n = 1'b1;
   logic oe_n = 1'b1;
   logic bm = 1'b0;
   logic rw = 1'b0;
   logic ww = 1'b0;
   logic [3:0] mode = 4'h0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   wire logic wclk, wen_n, rclk, ren_n, rt_n, ld_n, oe, ef_n, pae_n, paf_n, wb_ack_o;
   wire logic [35:0] wdata;
   wire logic [35:0] read_data_out_o;
   wire logic [31:0] wb_dat_o;
   int err_count = 0;
   int tests_run = 0;
   always #12.5 clk_i = ~clk_i;
   frfr_pin_partner pp (.clk_i(clk_i), .write_clk_o(wclk), .write_enable_n_o(wen_n), .write_data_o(wdata),
      .read_clk_o(rclk), .read_enable_n_o(ren_n), .retransmit_request_n_o(rt_n), .offset_access_select_n_o(ld_n));
   // Config pins below stay fixed between master resets
   frfr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .full_init_reset_n_i(mrs_n), .data_only_reset_n_i(prs_n),
      .write_clk_i(wclk), .write_enable_n_i(wen_n), .write_data_i(wdata), .read_clk_i(rclk),
      .read_enable_n_i(ren_n), .offset_access_select_n_i(ld_n), .retransmit_request_n_i(rt_n),
      .output_enable_n_i(oe_n), .fall_through_serial_in_i(1'b0), .read_width_select_i(rw),
      .write_width_select_i(ww), .bus_match_select_i(bm), .byte_order_select_i(mode[3]), .parity_select_i(mode[2]),
      .flag_timing_select_i(mode[1]), .retransmit_latency_select_i(mode[0]), .async_read_select_n_i(1'b1),
      .offset_default_select_i(2'h0), .read_data_out_o(read_data_out_o), .read_data_oe_o(oe),
      .empty_flag_n_o(ef_n), .near_empty_flag_n_o(pae_n), .near_full_flag_n_o(paf_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wb_check(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
      logic [31:0] rd;
      wb_cycle(1'b0, adr, 32'h0, rd);
      chk({4'h0, rd & mask}, {4'h0, exp});
   endtask
   task automatic pulse_reset(input logic full);
      @(posedge clk_i);
      if (full) mrs_n <= 1'b0;
      else prs_n <= 1'b0;
      repeat (8) @(posedge clk_i);
      mrs_n <= 1'b1;
      prs_n <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask
   task automatic t_defaults();
      pulse_reset(1'b1);
      chk(read_data_out_o, 36'h0);
      wb_check(frfr_pkg::ADR_OFFSETS, 32'h007F_007F, 32'hFFFF_FFFF);
      wb_check(frfr_pkg::ADR_STATUS, ST_IDLE, 32'h07FF_FFFF);
      wb_check(8'h08, 32'h0, 32'hFFFF_FFFF);
      oe_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(oe, 1'b1);
   endtask
   task automatic t_flags();
      logic [31:0] rd;
      wb_cycle(1'b1, frfr_pkg::ADR_OFFSETS, 32'h03FD_0003, rd);
      for (int i = 0; i < 3; i++) begin
         pp.write_word(WBASE + 36'(i));
         chk(pae_n, i == 2);
         chk(paf_n, i < 2);
      end
      chk(ef_n, 1'b1);
   endtask
   task automatic t_read();
      pp.read_edge(1'b0, 1'b1, 1'b1);
      chk(read_data_out_o, WBASE);
      pp.read_edge(1'b1, 1'b1, 1'b1);
      chk(read_data_out_o, WBASE);
      pp.read_edge(1'b0, 1'b1, 1'b1);
      chk(read_data_out_o, WBASE + 36'h1);
      pp.read_edge(1'b0, 1'b1, 1'b0);
      chk({26'h0, read_data_out_o[9:0]}, 36'h3);
      pp.read_edge(1'b0, 1'b1, 1'b0);
      chk({26'h0, read_data_out_o[9:0]}, 36'h3FD);
      wb_check(frfr_pkg::ADR_STATUS, 32'h1, 32'h7FF);
   endtask
   task automatic t_retx();
      pp.read_edge(1'b0, 1'b0, 1'b1);
      chk(ef_n, 1'b0);
      wb_check(frfr_pkg::ADR_STATUS, 32'h3, 32'h7FF);
      wb_check(frfr_pkg::ADR_OFFSETS, 32'h03FD_0003, 32'hFFFF_FFFF);
      pp.read_edge(1'b0, 1'b1, 1'b1);
      chk(read_data_out_o, WBASE);
      chk(ef_n, 1'b1);
   endtask
   task automatic t_prs();
      pulse_reset(1'b0);
      chk(read_data_out_o, 36'h0);
      chk(ef_n, 1'b0);
      wb_check(frfr_pkg::ADR_STATUS, ST_IDLE, 32'h07FF_FFFF);
      wb_check(frfr_pkg::ADR_OFFSETS, 32'h03FD_0003, 32'hFFFF_FFFF);
   endtask
   task automatic t_width();
      {bm, rw, mode} <= 6'h3F;
      pulse_reset(1'b1);
      wb_check(frfr_pkg::ADR_STATUS, 32'h0690_0000, 32'h07B0_0000);
      pp.write_word(36'h9_ABCD_1234);
      pp.read_edge(1'b0, 1'b1, 1'b1);
      chk(read_data_out_o, {18'h0, 18'h11234});
      pp.read_edge(1'b0, 1'b1, 1'b1);
      chk(read_data_out_o, {18'h0, 18'h26AF3});
      oe_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(oe, 1'b0);
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_defaults();
      t_flags();
      t_read();
      t_retx();
      t_prs();
      t_width();
      tally_and_finish();
   end
   // About 270 cycles are needed; 20,000 means a hang
   initial begin
      #500000;
      err_count++;
      tally_and_finish();
   end
endmodule
bind frfr_top frfr_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .full_init_reset_n_i(full_init_reset_n_i),
   .data_only_reset_n_i(data_only_reset_n_i), .fall_through_serial_in_i(fall_through_serial_in_i),
   .async_read_select_n_i(async_read_select_n_i), .output_enable_n_i(output_enable_n_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .read_data_out_o(read_data_out_o),
   .read_data_oe_o(read_data_oe_o), .empty_flag_n_o(empty_flag_n_o), .near_empty_flag_n_o(near_empty_flag_n_o),
   .near_full_flag_n_o(near_full_flag_n_o), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire
